/* File: lcd_host_asserts.sv */
// Port checks for the LCD host bus interface
`timescale 1ns/1ps
module lcd_host_asserts
#(
    parameter logic [7:0] CMD_SLEEP_IN = 8'hA3
)
(
    input wire logic                           clk_i,
    input wire logic                           rst_b_i,
    input wire logic                           interface_select_a_i,
    input wire logic                           interface_select_b_i,
    input wire logic                           interface_select_c_i,
    input wire logic                           cs_n_i,
    input wire logic [lcd_host_pkg::BUS_W-1:0] data_oe_n_o,
    input wire logic                           cmd_valid_o,
    input wire logic [lcd_host_pkg::BYTE_W-1:0] cmd_code_o,
    input wire logic                           param_valid_o,
    input wire logic                           display_ram_we_o,
    input wire logic                           display_ram_pair_o,
    input wire logic                           display_ram_re_o,
    input wire logic                           sleep_indicator_n_o
);
    import lcd_host_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Straps are synced, so each float check waits four cycles of a stable mode or of chip select high
    wire ser = !interface_select_a_i && !interface_select_b_i;
    wire nar = interface_select_b_i && (interface_select_a_i != interface_select_c_i);
    property p_cs_float; cs_n_i [*4] |-> &data_oe_n_o; endproperty
    a_cs_float: assert property (p_cs_float) else $error("bus driven while deselected");
    property p_ser_float; ser [*4] |-> &data_oe_n_o; endproperty
    a_ser_float: assert property (p_ser_float) else $error("bus driven in serial mode");
    property p_byte_float; nar [*4] |-> &data_oe_n_o[15:8]; endproperty
    a_byte_float: assert property (p_byte_float) else $error("upper byte driven in 8-bit mode");
    property p_ser_noread; ser [*4] |-> !display_ram_re_o; endproperty
    a_ser_noread: assert property (p_ser_noread) else $error("memory read in serial mode");
    property p_drive; !data_oe_n_o[0] |-> !$past(cs_n_i, 3) || !$past(cs_n_i, 4); endproperty
    a_drive: assert property (p_drive) else $error("bus driven without select");
    property p_sleep; cmd_valid_o && cmd_code_o == CMD_SLEEP_IN |-> ##[0:2] !sleep_indicator_n_o; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep indicator stayed high");
    property p_we; display_ram_we_o |-> param_valid_o; endproperty
    a_we: assert property (p_we) else $error("memory write without data write");
    property p_re; display_ram_re_o |-> &data_oe_n_o ##1 !display_ram_re_o; endproperty
    a_re: assert property (p_re) else $error("holder load during drive");
    property p_cmd; $rose(cmd_valid_o) |=> $fell(cmd_valid_o); endproperty
    a_cmd: assert property (p_cmd) else $error("command pulse too long");
    c_pair: cover property (display_ram_we_o && display_ram_pair_o);
    c_sleep: cover property ($fell(sleep_indicator_n_o));
    c_re: cover property (display_ram_re_o);
endmodule : lcd_host_asserts

bind lcd_host_bus_interface lcd_host_asserts #(.CMD_SLEEP_IN(CMD_SLEEP_IN)) u_chk (.*);

/* File: lcd_host_bus_interface.sv */
// Host bus interface of a colour LCD driver: parallel and serial ports, pixel packing, bus holder
`timescale 1ns/1ps

module lcd_host_bus_interface
#(
    parameter int         ADDR_W        = 16,
    parameter logic [7:0] CMD_PALETTE   = 8'hA0,
    parameter logic [7:0] CMD_MEM_WRITE = 8'hA1,
    parameter logic [7:0] CMD_MEM_READ  = 8'hA2,
    parameter logic [7:0] CMD_SLEEP_IN  = 8'hA3,
    parameter logic [7:0] CMD_SLEEP_OUT = 8'hA4
)
(
    input  wire logic                            clk_i,
    input  wire logic                            rst_b_i,
    input  wire logic                            interface_select_a_i,
    input  wire logic                            interface_select_b_i,
    input  wire logic                            interface_select_c_i,
    input  wire logic                            cs_n_i,
    input  wire logic                            cmd_data_select_i,
    input  wire logic                            rd_e_i,
    input  wire logic                            wr_rw_i,
    input  wire logic [lcd_host_pkg::BUS_W-1:0]  data_i,
    output logic      [lcd_host_pkg::BUS_W-1:0]  data_o,
    output logic      [lcd_host_pkg::BUS_W-1:0]  data_oe_n_o,
    input  wire logic                            scl_i,
    input  wire logic                            si_i,
    input  wire logic                            color_4096_i,
    input  wire logic [lcd_host_pkg::STATUS_W-1:0] status_i,
    output logic                                 cmd_valid_o,
    output logic      [lcd_host_pkg::BYTE_W-1:0] cmd_code_o,
    output logic                                 param_valid_o,
    output logic      [lcd_host_pkg::BYTE_W-1:0] param_data_o,
    output logic                                 display_ram_we_o,
    output logic                                 display_ram_pair_o,
    output logic      [ADDR_W-1:0]               display_ram_addr_o,
    output logic      [lcd_host_pkg::PIX_W-1:0]  display_ram_wdata0_o,
    output logic      [lcd_host_pkg::PIX_W-1:0]  display_ram_wdata1_o,
    output logic                                 display_ram_re_o,
    input  wire logic [lcd_host_pkg::PIX_W-1:0]  display_ram_rdata_i,
    output logic                                 sleep_indicator_n_o
);
    import lcd_host_pkg::*;

    if (ADDR_W < 2 || ADDR_W > 24)
    begin : g_bad_addr
        $error("ADDR_W must lie between 2 and 24");
    end

    // Pin synchronisers and decoded mode
    logic [SYNC_W-1:0] pin_s1_q;
    logic [SYNC_W-1:0] pin_s2_q;
    if_mode_type       mode_q;
    logic              ser_clr_q;

    logic [2:0]        sel_s;
    logic              cs_s;
    logic              a0_s;
    logic              rd_s;
    logic              wr_s;
    logic [BUS_W-1:0]  dat_s;

    // Serial domain
    logic              mode9_s1_q;
    logic              mode9_s2_q;
    logic [3:0]        ser_cnt_q;
    logic [BYTE_W-2:0] ser_sh_q;
    logic              ser_flag_q;
    logic [BYTE_W-1:0] ser_byte_q;
    logic              ser_dc_q;
    logic              ser_tgl_q;

    // Toggle receiver in the system domain
    logic [2:0]        tgl_sync_q;

    // Parallel access tracking
    logic              strobe_mode;
    logic              parallel_mode;
    logic              wide_mode;
    logic              rd_act;
    logic              wr_act;
    logic              rd_act_q;
    logic              wr_act_q;
    logic [BUS_W-1:0]  wr_hold_q;
    logic              a0_hold_q;
    logic              rd_a0_q;

    // Unified write event
    logic              ev_valid;
    logic              ev_dc;
    logic [BUS_W-1:0]  ev_data;
    logic              ev_wide;

    // Sequencing, palette, pixel packing, bus holder
    seq_type           seq_q;
    logic [4:0]        pal_idx_q;
    logic [NIB_W-1:0]  pal_q [PAL_ENTRIES];
    logic [1:0]        phase_q;
    logic [BYTE_W-1:0] byte0_q;
    logic [BYTE_W-1:0] byte1_q;
    logic [ADDR_W-1:0] ptr_q;
    logic              re_dly_q;
    logic [PIX_W-1:0]  holder_q;

    // Palette lookup of one RRRGGGBB byte
    function automatic logic [PIX_W-1:0] expand(input logic [BYTE_W-1:0] px);
        expand = {pal_q[PAL_RED_BASE + int'(px[RED_LSB+:3])],
                  pal_q[PAL_GREEN_BASE + int'(px[GREEN_LSB+:3])],
                  pal_q[PAL_BLUE_BASE + int'(px[BLUE_LSB+:2])]};
    endfunction : expand

    // The select, chip select, A0, strobe and data pins cross two flops before the parallel decode
    always_ff @(posedge clk_i)
    begin
        pin_s1_q <= {interface_select_a_i, interface_select_b_i, interface_select_c_i,
                     cs_n_i, cmd_data_select_i, rd_e_i, wr_rw_i, data_i};
        pin_s2_q <= pin_s1_q;
    end

    assign sel_s = pin_s2_q[SYNC_W-1 -: 3];
    assign cs_s  = pin_s2_q[BUS_W+3];
    assign a0_s  = pin_s2_q[BUS_W+2];
    assign rd_s  = pin_s2_q[BUS_W+1];
    assign wr_s  = pin_s2_q[BUS_W];
    assign dat_s = pin_s2_q[BUS_W-1:0];

    // Interface selection; unlisted codes leave the port dead
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            mode_q <= IF_NONE;
        end
        else
        begin
            case (sel_s)
                SEL_STROBE16: mode_q <= IF_STROBE16;
                SEL_STROBE8:  mode_q <= IF_STROBE8;
                SEL_ENABLE16: mode_q <= IF_ENABLE16;
                SEL_ENABLE8:  mode_q <= IF_ENABLE8;
                SEL_SERIAL9:  mode_q <= IF_SERIAL9;
                SEL_SERIAL8:  mode_q <= IF_SERIAL8;
                default:      mode_q <= IF_NONE;
            endcase
        end
    end

    // Registered reset clears the serial side, whose clock may be stopped
    always_ff @(posedge clk_i)
    begin
        ser_clr_q <= !rst_b_i;
    end

    // Mode level into the serial clock domain
    always_ff @(posedge scl_i or posedge ser_clr_q)
    begin
        if (ser_clr_q)
        begin
            mode9_s1_q <= 1'b0;
            mode9_s2_q <= 1'b0;
        end
        else
        begin
            mode9_s1_q <= (mode_q == IF_SERIAL9);
            mode9_s2_q <= mode9_s1_q;
        end
    end

    // Bit counter and shifter; chip select high drops a partial byte
    always_ff @(posedge scl_i or posedge cs_n_i or posedge ser_clr_q)
    begin
        if (cs_n_i || ser_clr_q)
        begin
            ser_cnt_q  <= SER_FIRST;
            ser_sh_q   <= '0;
            ser_flag_q <= 1'b0;
        end
        else if (mode9_s2_q && ser_cnt_q == SER_FIRST)
        begin
            ser_flag_q <= si_i;
            ser_cnt_q  <= ser_cnt_q + 4'h1;
        end
        else if (ser_cnt_q == (mode9_s2_q ? SER_LAST9 : SER_LAST8))
        begin
            ser_cnt_q <= SER_FIRST;
        end
        else
        begin
            ser_sh_q  <= {ser_sh_q[BYTE_W-3:0], si_i};
            ser_cnt_q <= ser_cnt_q + 4'h1;
        end
    end

    // Completed byte is held steady and announced by a toggle
    always_ff @(posedge scl_i or posedge ser_clr_q)
    begin
        if (ser_clr_q)
        begin
            ser_byte_q <= ZERO_BYTE;
            ser_dc_q   <= 1'b0;
            ser_tgl_q  <= 1'b0;
        end
        else if (!cs_n_i && ser_cnt_q == (mode9_s2_q ? SER_LAST9 : SER_LAST8))
        begin
            ser_byte_q <= {ser_sh_q, si_i};
            ser_dc_q   <= mode9_s2_q ? ser_flag_q : cmd_data_select_i;
            ser_tgl_q  <= !ser_tgl_q;
        end
    end

    // Toggle crossing; byte stays stable for seven more serial edges
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            tgl_sync_q <= 3'h0;
        end
        else
        begin
            tgl_sync_q <= {tgl_sync_q[1:0], ser_tgl_q};
        end
    end

    // Parallel strobe decode, qualified by chip select
    assign strobe_mode   = (mode_q == IF_STROBE16) || (mode_q == IF_STROBE8);
    assign parallel_mode = strobe_mode || (mode_q == IF_ENABLE16) || (mode_q == IF_ENABLE8);
    assign wide_mode     = (mode_q == IF_STROBE16) || (mode_q == IF_ENABLE16);
    assign rd_act = parallel_mode && !cs_s && (strobe_mode ? !rd_s : (rd_s && wr_s));
    assign wr_act = parallel_mode && !cs_s && (strobe_mode ? !wr_s : (rd_s && !wr_s));

    // Track write data up to the closing edge of the strobe
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rd_act_q  <= 1'b0;
            wr_act_q  <= 1'b0;
            wr_hold_q <= '0;
            a0_hold_q <= 1'b0;
            rd_a0_q   <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (wr_act)
            begin
                wr_hold_q <= dat_s;
                a0_hold_q <= a0_s;
            end
            if (rd_act)
            begin
                rd_a0_q <= a0_s;
            end
        end
    end

    // One write event from either port; serial carries one byte like 8-bit parallel
    always_comb
    begin
        ev_valid = 1'b0;
        ev_dc    = 1'b0;
        ev_data  = '0;
        ev_wide  = 1'b0;
        if (wr_act_q && !wr_act)
        begin
            ev_valid = 1'b1;
            ev_dc    = a0_hold_q;
            ev_data  = wr_hold_q;
            ev_wide  = wide_mode;
        end
        else if ((tgl_sync_q[2] != tgl_sync_q[1]) && (mode_q == IF_SERIAL9 || mode_q == IF_SERIAL8))
        begin
            ev_valid = 1'b1;
            ev_dc    = ser_dc_q;
            ev_data  = {ZERO_BYTE, ser_byte_q};
        end
    end

    // Command and parameter strobes to the command decoder
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cmd_valid_o   <= 1'b0;
            cmd_code_o    <= ZERO_BYTE;
            param_valid_o <= 1'b0;
            param_data_o  <= ZERO_BYTE;
        end
        else
        begin
            cmd_valid_o   <= ev_valid && !ev_dc;
            param_valid_o <= ev_valid && ev_dc;
            if (ev_valid && !ev_dc)
            begin
                cmd_code_o <= ev_data[BYTE_W-1:0];
            end
            if (ev_valid && ev_dc)
            begin
                param_data_o <= ev_data[BYTE_W-1:0];
            end
        end
    end

    // Which stream the data writes belong to
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            seq_q     <= SEQ_IDLE;
            pal_idx_q <= 5'h00;
        end
        else if (ev_valid && !ev_dc)
        begin
            pal_idx_q <= 5'h00;
            if (ev_data[BYTE_W-1:0] == CMD_PALETTE)
            begin
                seq_q <= SEQ_PALETTE;
            end
            else if (ev_data[BYTE_W-1:0] == CMD_MEM_WRITE)
            begin
                seq_q <= SEQ_WRITE;
            end
            else if (ev_data[BYTE_W-1:0] == CMD_MEM_READ)
            begin
                seq_q <= SEQ_READ;
            end
            else
            begin
                seq_q <= SEQ_IDLE;
            end
        end
        else if (ev_valid && seq_q == SEQ_PALETTE)
        begin
            case (pal_idx_q == PAL_LAST)
                1'b1:    seq_q <= SEQ_IDLE;
                default: pal_idx_q <= pal_idx_q + 5'h01;
            endcase
        end
    end

    // Palette entries take the low nibble of each parameter byte
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < PAL_ENTRIES; i++)
            begin
                pal_q[i] <= PAL_RESET;
            end
        end
        else if (ev_valid && ev_dc && seq_q == SEQ_PALETTE)
        begin
            pal_q[pal_idx_q] <= ev_data[NIB_W-1:0];
        end
    end

    // Pixel packing into the write side of the bus holder
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            display_ram_we_o     <= 1'b0;
            display_ram_pair_o   <= 1'b0;
            display_ram_wdata0_o <= DUMMY_PIXEL;
            display_ram_wdata1_o <= DUMMY_PIXEL;
            display_ram_re_o     <= 1'b0;
            display_ram_addr_o   <= '0;
            ptr_q                <= '0;
            phase_q              <= PH_FIRST;
            byte0_q              <= ZERO_BYTE;
            byte1_q              <= ZERO_BYTE;
        end
        else
        begin
            display_ram_we_o <= 1'b0;
            display_ram_re_o <= 1'b0;
            if (ev_valid && !ev_dc)
            begin
                ptr_q   <= '0;                                 // Pointer restarts on any command
                phase_q <= PH_FIRST;
            end
            else if (ev_valid && seq_q == SEQ_WRITE)
            begin
                display_ram_addr_o <= ptr_q;
                if (!color_4096_i && ev_wide)
                begin
                    display_ram_we_o     <= 1'b1;
                    display_ram_pair_o   <= 1'b1;
                    display_ram_wdata0_o <= expand(ev_data[BUS_W-1:BYTE_W]);
                    display_ram_wdata1_o <= expand(ev_data[BYTE_W-1:0]);
                    ptr_q                <= ptr_q + ADDR_W'(2);
                end
                else if (!color_4096_i)
                begin
                    display_ram_we_o     <= 1'b1;
                    display_ram_pair_o   <= 1'b0;
                    display_ram_wdata0_o <= expand(ev_data[BYTE_W-1:0]);
                    ptr_q                <= ptr_q + ADDR_W'(1);
                end
                else if (ev_wide)
                begin
                    display_ram_we_o     <= 1'b1;
                    display_ram_pair_o   <= 1'b0;
                    display_ram_wdata0_o <= ev_data[BUS_W-1:NIB_W];
                    ptr_q                <= ptr_q + ADDR_W'(1);
                end
                else
                begin
                    case (phase_q)
                        PH_FIRST:
                        begin
                            byte0_q <= ev_data[BYTE_W-1:0];
                            phase_q <= PH_SECOND;
                        end
                        PH_SECOND:
                        begin
                            byte1_q <= ev_data[BYTE_W-1:0];
                            phase_q <= PH_THIRD;
                        end
                        default:
                        begin
                            display_ram_we_o     <= 1'b1;
                            display_ram_pair_o   <= 1'b1;
                            display_ram_wdata0_o <= {byte0_q, byte1_q[BYTE_W-1:NIB_W]};
                            display_ram_wdata1_o <= {byte1_q[NIB_W-1:0], ev_data[BYTE_W-1:0]};
                            ptr_q                <= ptr_q + ADDR_W'(2);
                            phase_q              <= PH_FIRST;
                        end
                    endcase
                end
            end
            else if (rd_act_q && !rd_act && rd_a0_q && seq_q == SEQ_READ)
            begin
                display_ram_re_o   <= 1'b1;
                display_ram_addr_o <= ptr_q;
                ptr_q              <= ptr_q + ADDR_W'(1);
            end
        end
    end

    // Read side of the holder: each read shows the word fetched by the one before
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            re_dly_q <= 1'b0;
            holder_q <= DUMMY_PIXEL;
        end
        else
        begin
            re_dly_q <= display_ram_re_o;
            if (ev_valid && !ev_dc && ev_data[BYTE_W-1:0] == CMD_MEM_READ)
            begin
                holder_q <= DUMMY_PIXEL;
            end
            else if (re_dly_q)
            begin
                holder_q <= display_ram_rdata_i;
            end
        end
    end

    // Bus drive; enables follow the strobe, a lane is driven only when it exists
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            data_o      <= '0;
            data_oe_n_o <= '1;
        end
        else
        begin
            data_oe_n_o[BUS_W-1:BYTE_W] <= {BYTE_W{!(rd_act && wide_mode)}};
            data_oe_n_o[BYTE_W-1:0]     <= {BYTE_W{!rd_act}};
            if (rd_act && !rd_act_q)
            begin
                if (!a0_s)
                begin
                    data_o <= {ZERO_BYTE, status_i};
                end
                else if (wide_mode)
                begin
                    data_o <= {holder_q, PAD_NIBBLE};
                end
                else
                begin
                    data_o <= {ZERO_BYTE, holder_q[PIX_W-1:NIB_W]};
                end
            end
        end
    end

    // Sleep indicator follows the sleep commands
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sleep_indicator_n_o <= 1'b1;
        end
        else if (ev_valid && !ev_dc && ev_data[BYTE_W-1:0] == CMD_SLEEP_IN)
        begin
            sleep_indicator_n_o <= 1'b0;
        end
        else if (ev_valid && !ev_dc && ev_data[BYTE_W-1:0] == CMD_SLEEP_OUT)
        begin
            sleep_indicator_n_o <= 1'b1;
        end
    end

endmodule : lcd_host_bus_interface

/* File: lcd_host_bus_interface_tb.sv */
// Self-checking bench for the LCD host bus interface
`timescale 1ns/1ps
module lcd_host_bus_interface_tb;
    import lcd_host_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, pcs = 1'b1, en = 1'b0, p_q;
    logic        cmd_data_select_i = 1'b1, rd_e_i = 1'b1, wr_rw_i = 1'b1, color_4096_i = 1'b0;
    logic [2:0]  sel = SEL_STROBE16;
    logic [15:0] data_i = 16'h0000, data_o, data_oe_n_o, display_ram_addr_o, a_q;
    logic [11:0] display_ram_wdata0_o, display_ram_wdata1_o, w0_q, w1_q;
    logic [7:0]  status_i = 8'h5A, cmd_code_o, param_data_o;
    logic        cmd_valid_o, param_valid_o, display_ram_we_o, display_ram_pair_o;
    logic        display_ram_re_o, sleep_indicator_n_o;
    wire         scl_i, si_i, scs;
    wire         cs_n_i = pcs & scs;
    wire  [11:0] display_ram_rdata_i = display_ram_addr_o[11:0] ^ 12'hABC;
    wire         interface_select_a_i = sel[2], interface_select_b_i = sel[1], interface_select_c_i = sel[0];
    int          err_total = 0, cmp_count = 0;
    lcd_host_bus_interface u_dut (.*);
    lcd_serial_host u_host (.scl_o(scl_i), .si_o(si_i), .cs_n_o(scs));
    initial forever #25 clk_i = ~clk_i;
    // Hold the last pixel write for later checks
    always @(posedge clk_i)
        if (display_ram_we_o === 1'b1)
        begin
            w0_q <= display_ram_wdata0_o;
            w1_q <= display_ram_wdata1_o;
            a_q <= display_ram_addr_o;
            p_q <= display_ram_pair_o;
        end
    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // Write: strobe or enable held four cycles, data past its end
    task pwr(input logic a, input logic [15:0] d);
        pcs = 1'b0;
        cmd_data_select_i = a;
        data_i = d;
        if (en) rd_e_i = 1'b1; else wr_rw_i = 1'b0;
        cyc(4);
        if (en) rd_e_i = 1'b0; else wr_rw_i = 1'b1;
        cyc(4);
        pcs = 1'b1;
        cyc(2);
    endtask : pwr
    task prd(input logic a, input logic [15:0] d, input logic [15:0] oe);
        pcs = 1'b0;
        cmd_data_select_i = a;
        rd_e_i = en;
        wr_rw_i = 1'b1;
        cyc(6);
        chk(data_o, d);
        chk(data_oe_n_o, oe);
        rd_e_i = !en;
        cyc(5);
        pcs = 1'b1;
        wr_rw_i = !en;
        cyc(2);
    endtask : prd
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // About 37 times the expected run
    initial
    begin
        #1000000;
        err_total++;
        finish_test;
    end
    initial
    begin
        cyc(3);
        chk(data_oe_n_o, 16'hFFFF);
        rst_b_i = 1'b1;
        cyc(5);
        prd(1'b0, 16'h005A, 16'h0000);
        pwr(1'b0, 16'h00A1);
        color_4096_i = 1'b1;
        pwr(1'b1, 16'h123F);
        chk({4'h0, w0_q}, 16'h0123);
        color_4096_i = 1'b0;
        pwr(1'b0, 16'h00A0);
        for (int i = 0; i < 20; i++) pwr(1'b1, 16'(i));
        pwr(1'b0, 16'h00A1);
        pwr(1'b1, 16'hFF00);
        chk({4'h0, w0_q}, 16'h07F3);
        chk({4'h0, w1_q}, 16'h0080);
        chk({15'h0, p_q}, 16'h0001);
        chk(a_q, 16'h0000);
        pwr(1'b0, 16'h00A2);
        prd(1'b1, 16'h0000, 16'h0000);
        prd(1'b1, 16'hABC0, 16'h0000);
        prd(1'b1, 16'hABD0, 16'h0000);
        $display("test strobe16 done");
        sel = SEL_STROBE8;
        color_4096_i = 1'b1;
        cyc(4);
        pwr(1'b0, 16'h00A1);
        for (int i = 0; i < 3; i++) pwr(1'b1, 16'h0012 + 16'(i) * 16'h0022);
        chk({4'h0, w0_q}, 16'h0123);
        chk({4'h0, w1_q}, 16'h0456);
        prd(1'b0, 16'h005A, 16'hFF00);
        $display("test strobe8 done");
        sel = SEL_ENABLE16;
        en = 1'b1;
        rd_e_i = 1'b0;
        wr_rw_i = 1'b0;
        cyc(4);
        pwr(1'b0, 16'h00A3);
        chk({15'h0, sleep_indicator_n_o}, 16'h0000);
        sel = SEL_ENABLE8;
        cyc(4);
        prd(1'b0, 16'h005A, 16'hFF00);
        $display("test enable done");
        sel = SEL_SERIAL8;
        cmd_data_select_i = 1'b0;
        cyc(4);
        u_host.send(9'h0A4, 8);
        cyc(8);
        chk({15'h0, sleep_indicator_n_o}, 16'h0001);
        u_host.send(9'h0A3, 7);
        cyc(8);
        chk({15'h0, sleep_indicator_n_o}, 16'h0001);
        u_host.send(9'h0A3, 8);
        cyc(8);
        chk({8'h00, cmd_code_o}, 16'h00A3);
        chk(data_oe_n_o, 16'hFFFF);
        cmd_data_select_i = 1'b1;
        u_host.send(9'h05A, 8);
        cyc(8);
        chk({8'h00, param_data_o}, 16'h005A);
        $display("test serial8 done");
        sel = SEL_SERIAL9;
        cyc(4);
        u_host.wake;
        u_host.send(9'h1C3, 9);
        cyc(8);
        chk({8'h00, param_data_o}, 16'h00C3);
        u_host.send(9'h0A4, 9);
        cyc(8);
        chk({15'h0, sleep_indicator_n_o}, 16'h0001);
        $display("test serial9 done");
        finish_test;
    end
endmodule : lcd_host_bus_interface_tb

/* File: lcd_host_pkg.sv */
// Shared constants and types for the LCD host bus interface
package lcd_host_pkg;

    // Interface select pin codes, ordered {select_a, select_b, select_c}
    localparam logic [2:0] SEL_STROBE16 = 3'h7;
    localparam logic [2:0] SEL_STROBE8  = 3'h6;
    localparam logic [2:0] SEL_ENABLE16 = 3'h4;
    localparam logic [2:0] SEL_ENABLE8  = 3'h3;
    localparam logic [2:0] SEL_SERIAL9  = 3'h1;
    localparam logic [2:0] SEL_SERIAL8  = 3'h0;

    // Decoded host interface
    typedef enum logic [2:0] {
        IF_STROBE16 = 3'b000,
        IF_STROBE8  = 3'b001,
        IF_ENABLE16 = 3'b010,
        IF_ENABLE8  = 3'b011,
        IF_SERIAL9  = 3'b100,
        IF_SERIAL8  = 3'b101,
        IF_NONE     = 3'b110
    } if_mode_type;

    // What data writes currently feed
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_PALETTE = 2'b01,
        SEQ_WRITE   = 2'b10,
        SEQ_READ    = 2'b11
    } seq_type;

    // Widths
    localparam int BUS_W    = 16;
    localparam int BYTE_W   = 8;
    localparam int NIB_W    = 4;
    localparam int PIX_W    = 12;
    localparam int STATUS_W = 8;
    localparam int SYNC_W   = 23;

    // Palette layout: eight red, eight green, four blue intensities
    localparam int PAL_RED_BASE   = 0;
    localparam int PAL_GREEN_BASE = 8;
    localparam int PAL_BLUE_BASE  = 16;
    localparam int PAL_ENTRIES    = 20;
    localparam logic [4:0] PAL_LAST = 5'h13;

    // 256-colour byte fields RRRGGGBB
    localparam int RED_LSB   = 5;
    localparam int GREEN_LSB = 2;
    localparam int BLUE_LSB  = 0;

    // Serial bit counter end points (payload is eight bits)
    localparam logic [3:0] SER_LAST8 = 4'h7;
    localparam logic [3:0] SER_LAST9 = 4'h8;
    localparam logic [3:0] SER_FIRST = 4'h0;

    // 4096-colour 8-bit byte phases
    localparam logic [1:0] PH_FIRST  = 2'h0;
    localparam logic [1:0] PH_SECOND = 2'h1;
    localparam logic [1:0] PH_THIRD  = 2'h2;

    // Reset and fill values
    localparam logic [11:0] DUMMY_PIXEL = 12'h000;
    localparam logic [3:0]  PAD_NIBBLE  = 4'h0;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    localparam logic [3:0]  PAL_RESET   = 4'h0;

endpackage : lcd_host_pkg

/* File: lcd_serial_host.sv */
// Serial host model for the write-only link
`timescale 1ns/1ps
module lcd_serial_host
(
    output logic scl_o,
    output logic si_o,
    output logic cs_n_o
);
    // Link clock stands low and select high between frames
    initial
    begin
        scl_o = 1'b0;
        si_o = 1'b0;
        cs_n_o = 1'b1;
    end
    // Sends n bits MSB first at 48 ns; n below 8 aborts the frame
    task automatic send(input logic [8:0] b, input int n);
        cs_n_o = 1'b0;
        #17;
        for (int i = n - 1; i >= 0; i--)
        begin
            si_o = b[i];
            #24 scl_o = 1'b1;
            #24 scl_o = 1'b0;
        end
        si_o = ~si_o; // Released line must not keep its value
        #13 cs_n_o = 1'b1;
        #200;
    endtask : send
    // Idle link clocks carry a mode change across
    task automatic wake;
        repeat (2)
        begin
            #24 scl_o = 1'b1;
            #24 scl_o = 1'b0;
        end
    endtask : wake
endmodule : lcd_serial_host
